/* File: src/serial_port_dtr_dsr_flow.sv */
// Serial port with terminal-ready hold-off and data-set-ready pacing.
`default_nettype none

module serial_port_dtr_dsr_flow #(
  parameter int CLK_HZ = serial_port_pkg::CLK_HZ,
  parameter int FULL_LEVEL = serial_port_pkg::BUF_FULL_LEVEL,
  parameter int OVERRUN = serial_port_pkg::OVERRUN_CHARS
) (
  input wire logic ref_clk,               // System clock, 125 MHz.
  input wire logic rst,                   // Synchronous reset, high.
  input wire logic [2:0] baudSel,         // Bit rate select code.
  input wire serial_port_pkg::fmt_t fmt,  // Parity and data width.
  input wire logic rxd,                   // Serial line in.
  output logic txd,                       // Serial line out.
  output logic dtr,                       // Terminal-ready, high is true.
  input wire logic dsr,                   // Data-set-ready, high is true.
  output logic [7:0] rxData,              // Head of the input buffer.
  output logic rxValid,                   // Input buffer not empty.
  input wire logic rxRead,                // Pop the head character.
  output logic msgEnd,                    // Pulse: newline stored.
  output logic rxError,                   // Pulse: bad frame or parity.
  output logic rxOverrun,                 // Pulse: character lost.
  input wire logic queryDone,             // Pulse: a query was processed.
  input wire logic [7:0] txData,          // Character to send.
  input wire logic txValid,               // txData is offered.
  input wire logic txLast,                // Last character of a response.
  output logic txReady,                   // Character taken this cycle.
  output logic txPaused,                  // Waiting on data-set-ready.
  output logic devClear,                  // Pulse: clear action.
  input wire logic cmdRemote,             // Pulse: enter remote.
  input wire logic cmdLocal,              // Pulse: return to local.
  input wire logic cmdLockout,            // Pulse: remote_lockout_command.
  output logic cmdEnable,                 // Serial commands may run.
  output logic localKeyEnable,            // Return-to-local key works.
  output logic panelKeysEnable,           // Other front-panel keys work.
  input wire logic [4:0] busAddr,         // Parallel-bus address.
  input wire logic serialSelect,          // Serial is the active interface.
  output logic talkOnly                   // Send readings unaddressed.
);

  localparam int CNT_W = $clog2(CLK_HZ / serial_port_pkg::SLOWEST_BAUD + 1);
  localparam int BUF_DEPTH = FULL_LEVEL + OVERRUN;
  localparam int PTR_W = $clog2(BUF_DEPTH);
  localparam int LVL_W = $clog2(BUF_DEPTH + 1);

  logic [CNT_W-1:0] bitCycles;
  serial_port_pkg::rx_state_t rxState_reg;
  logic [CNT_W-1:0] rxCyc_reg;
  logic [3:0] rxIdx_reg;
  logic [serial_port_pkg::AFTER_START_BITS-1:0] rxShift_reg;
  logic rxDone_reg;
  logic [7:0] rxChar;
  logic rxFrameOk;
  logic rxParityOk;
  logic rxGood;
  logic clearEvt;
  logic push;
  logic pop;
  logic [7:0] mem [BUF_DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W-1:0] rdPtr_reg;
  logic [LVL_W-1:0] level_reg;
  logic bufFull;
  logic nlSeen_reg;
  logic respHold_reg;
  logic respSet;
  logic respDone;
  serial_port_pkg::tx_state_t txState_reg;
  logic [7:0] txChar_reg;
  logic txLast_reg;
  logic txLoad;
  logic txBusy;
  serial_port_pkg::mode_t mode_reg;

  // Cycles per bit from the rate code; codes above the table fall back
  // to the default rate.
  always_comb begin
    unique case (baudSel)
      3'h0: bitCycles = CNT_W'(CLK_HZ / serial_port_pkg::BAUD_RATE[0]);
      3'h1: bitCycles = CNT_W'(CLK_HZ / serial_port_pkg::BAUD_RATE[1]);
      3'h2: bitCycles = CNT_W'(CLK_HZ / serial_port_pkg::BAUD_RATE[2]);
      3'h3: bitCycles = CNT_W'(CLK_HZ / serial_port_pkg::BAUD_RATE[3]);
      3'h4: bitCycles = CNT_W'(CLK_HZ / serial_port_pkg::BAUD_RATE[4]);
      default: bitCycles = CNT_W'(CLK_HZ / serial_port_pkg::BAUD_RATE[5]);
    endcase
  end

  // Receiver: find the start edge, confirm it at mid-bit, then take ten
  // mid-bit samples covering data, parity and both stop bits.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxState_reg <= serial_port_pkg::RX_IDLE;
      rxCyc_reg <= '0;
      rxIdx_reg <= 4'h0;
      rxShift_reg <= '1;
      rxDone_reg <= 1'b0;
    end else begin
      rxDone_reg <= 1'b0;
      unique case (rxState_reg)
        serial_port_pkg::RX_IDLE: begin
          rxCyc_reg <= '0;
          if (rxd == serial_port_pkg::START_LEVEL) begin
            rxState_reg <= serial_port_pkg::RX_START;
          end
        end
        serial_port_pkg::RX_START: begin
          if (rxCyc_reg == (bitCycles >> 1)) begin
            rxCyc_reg <= '0;
            rxIdx_reg <= 4'h0;
            if (rxd == serial_port_pkg::START_LEVEL) begin
              rxState_reg <= serial_port_pkg::RX_BITS;
            end else begin
              rxState_reg <= serial_port_pkg::RX_IDLE;
            end
          end else begin
            rxCyc_reg <= rxCyc_reg + 1'b1;
          end
        end
        serial_port_pkg::RX_BITS: begin
          if (rxCyc_reg == bitCycles - 1'b1) begin
            rxCyc_reg <= '0;
            rxShift_reg <= {rxd, rxShift_reg[
              serial_port_pkg::AFTER_START_BITS-1:1]};
            rxIdx_reg <= rxIdx_reg + 4'h1;
            if (rxIdx_reg ==
                4'(serial_port_pkg::AFTER_START_BITS - 1)) begin
              rxDone_reg <= 1'b1;
              rxState_reg <= serial_port_pkg::RX_IDLE;
            end
          end else begin
            rxCyc_reg <= rxCyc_reg + 1'b1;
          end
        end
        default: begin
          rxState_reg <= serial_port_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Frame checks: both stop bits high and, for seven-bit formats, the
  // parity sense as selected.
  always_comb begin
    rxFrameOk = rxShift_reg[serial_port_pkg::STOP1_POS] &
                rxShift_reg[serial_port_pkg::STOP2_POS];
    if (fmt == serial_port_pkg::FMT_NONE_8) begin
      rxChar = rxShift_reg[7:0];
      rxParityOk = 1'b1;
    end else begin
      rxChar = {1'b0, rxShift_reg[6:0]};
      rxParityOk = (^rxShift_reg[serial_port_pkg::PARITY_POS:0]) ==
                   (fmt == serial_port_pkg::FMT_ODD_7);
    end
  end

  // A good character is the clear request, goes to the buffer, or is lost when the buffer holds FULL_LEVEL + OVERRUN characters.
  // Returns are stored like any character; the newline ends the message.
  assign rxGood = rxDone_reg && rxFrameOk && rxParityOk;
  assign clearEvt = rxGood && (rxChar == serial_port_pkg::CHAR_CTRL_C);
  assign push = rxGood && !clearEvt && (level_reg < LVL_W'(BUF_DEPTH));
  assign pop = rxRead && (level_reg != '0) && !clearEvt;
  assign bufFull = level_reg >= LVL_W'(FULL_LEVEL);

  // Input buffer storage; room above the hold-off level takes the host's
  // late characters.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= rxChar;
    end
  end

  // Buffer pointers and fill level; a clear empties the buffer.
  always_ff @(posedge ref_clk) begin
    if (rst || clearEvt) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 :
                     wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 :
                     rdPtr_reg + 1'b1;
      end
      level_reg <= level_reg + LVL_W'(push) - LVL_W'(pop);
    end
  end

  assign rxData = mem[rdPtr_reg];
  assign rxValid = level_reg != '0;

  // Receive event pulses.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      msgEnd <= 1'b0;
      rxError <= 1'b0;
      rxOverrun <= 1'b0;
      devClear <= 1'b0;
    end else begin
      msgEnd <= push && (rxChar == serial_port_pkg::CHAR_NEWLINE);
      rxError <= rxDone_reg && !(rxFrameOk && rxParityOk);
      rxOverrun <= rxGood && !clearEvt && !push;
      devClear <= clearEvt;
    end
  end

  // Newline seen since the last response hold began.
  always_ff @(posedge ref_clk) begin
    if (rst || clearEvt || respSet) begin
      nlSeen_reg <= 1'b0;
    end else if (push && rxChar == serial_port_pkg::CHAR_NEWLINE) begin
      nlSeen_reg <= 1'b1;
    end
  end

  // Response hold: a processed query after its newline holds the host
  // off until the last response character has left the line. Setting
  // wins over the end of an earlier response in the same cycle.
  assign respSet = queryDone && (nlSeen_reg ||
                   (push && rxChar == serial_port_pkg::CHAR_NEWLINE));
  always_ff @(posedge ref_clk) begin
    if (rst || clearEvt) begin
      respHold_reg <= 1'b0;
    end else if (respSet) begin
      respHold_reg <= 1'b1;
    end else if (respDone) begin
      respHold_reg <= 1'b0;
    end
  end

  // Transmit sequencer: take a character, check data-set-ready before
  // it, then wait for the serialiser to finish the frame.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txState_reg <= serial_port_pkg::TX_IDLE;
      txChar_reg <= 8'h00;
      txLast_reg <= 1'b0;
    end else begin
      unique case (txState_reg)
        serial_port_pkg::TX_IDLE: begin
          if (txReady) begin
            txChar_reg <= txData;
            txLast_reg <= txLast;
            txState_reg <= serial_port_pkg::TX_CHECK_DSR;
          end
        end
        serial_port_pkg::TX_CHECK_DSR: begin
          if (clearEvt) begin
            txState_reg <= serial_port_pkg::TX_IDLE;
          end else if (dsr) begin
            txState_reg <= serial_port_pkg::TX_SEND;
          end
        end
        serial_port_pkg::TX_SEND: begin
          if (!txBusy) begin
            txState_reg <= serial_port_pkg::TX_IDLE;
          end
        end
        default: begin
          txState_reg <= serial_port_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // A character in flight is finished so the line stays well framed;
  // anything not yet started is discarded on a clear.
  assign txReady = (txState_reg == serial_port_pkg::TX_IDLE) &&
                   txValid && !clearEvt;
  assign txLoad = (txState_reg == serial_port_pkg::TX_CHECK_DSR) &&
                  dsr && !clearEvt;
  assign txPaused = (txState_reg == serial_port_pkg::TX_CHECK_DSR) &&
                    !dsr;
  assign respDone = (txState_reg == serial_port_pkg::TX_SEND) &&
                    !txBusy && txLast_reg;

  serial_char_tx #(
    .CNT_W(CNT_W)
  ) u_char_tx (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(txLoad),
    .charData(txChar_reg),
    .fmt(fmt),
    .bitCycles(bitCycles),
    .txd(txd),
    .busy(txBusy)
  );

  // Terminal-ready: false while the buffer is full, a response is owed,
  // or output waits on data-set-ready.
  always_ff @(posedge ref_clk) begin
    if (rst || clearEvt) begin
      dtr <= 1'b1;
    end else begin
      dtr <= !bufFull && !respHold_reg && !txPaused;
    end
  end

  // Front-panel mode follows the decoded remote, local and lockout
  // commands; a clear leaves the mode alone.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= serial_port_pkg::MODE_LOCAL;
    end else if (cmdLockout) begin
      mode_reg <= serial_port_pkg::MODE_LOCKOUT;
    end else if (cmdRemote) begin
      mode_reg <= serial_port_pkg::MODE_REMOTE;
    end else if (cmdLocal) begin
      mode_reg <= serial_port_pkg::MODE_LOCAL;
    end
  end

  // Mode outputs and talk-only selection.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmdEnable <= 1'b0;
      localKeyEnable <= 1'b1;
      panelKeysEnable <= 1'b1;
      talkOnly <= 1'b0;
    end else begin
      cmdEnable <= mode_reg != serial_port_pkg::MODE_LOCAL;
      localKeyEnable <= mode_reg != serial_port_pkg::MODE_LOCKOUT;
      panelKeysEnable <= mode_reg == serial_port_pkg::MODE_LOCAL;
      talkOnly <= serialSelect &&
                  (busAddr == serial_port_pkg::TALK_ONLY_ADDR) &&
                  (mode_reg == serial_port_pkg::MODE_LOCAL);
    end
  end

endmodule
`default_nettype wire

/* File: src/serial_port_pkg.sv */
// Constants and types shared by the serial port design files.
`default_nettype none
package serial_port_pkg;

  // Clock rate and the selectable bit rates, indexed by the rate select code.
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_RATE [6] = '{300, 600, 1200, 2400, 4800, 9600};
  localparam int SLOWEST_BAUD = 300;
  localparam logic [2:0] BAUD_SEL_9600 = 3'h5;
  localparam logic [2:0] BAUD_SEL_DEFAULT = BAUD_SEL_9600;

  // Character formats: parity and data width.
  typedef enum logic [1:0] {
    FMT_NONE_8 = 2'b00,
    FMT_EVEN_7 = 2'b01,
    FMT_ODD_7 = 2'b10
  } fmt_t;
  localparam fmt_t FMT_DEFAULT = FMT_NONE_8;

  // Frame layout: one start bit, then ten bits of data, parity and stops.
  // Eight data bits or seven data bits plus parity both give eleven bits.
  localparam int FRAME_BITS = 11;
  localparam int AFTER_START_BITS = 10;
  localparam int PARITY_POS = 7;
  localparam int STOP1_POS = 8;
  localparam int STOP2_POS = 9;
  localparam logic IDLE_LEVEL = 1'h1;
  localparam logic START_LEVEL = 1'h0;

  // Special received characters.
  localparam logic [7:0] CHAR_NEWLINE = 8'h0a;
  localparam logic [7:0] CHAR_RETURN = 8'h0d;
  localparam logic [7:0] CHAR_CTRL_C = 8'h03;

  // Input buffer: hold-off level and the overrun the host may still send.
  localparam int BUF_FULL_LEVEL = 100;
  localparam int OVERRUN_CHARS = 10;

  // Parallel-bus address that selects talk-only output.
  localparam logic [4:0] TALK_ONLY_ADDR = 5'h1f;

  // Front-panel modes.
  typedef enum logic [1:0] {
    MODE_LOCAL = 2'b00,
    MODE_REMOTE = 2'b01,
    MODE_LOCKOUT = 2'b10
  } mode_t;

  // Receiver and transmitter sequencing.
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_CHECK_DSR = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;

endpackage
`default_nettype wire

/* File: src/serial_char_tx.sv */
// Character serialiser: builds one eleven-bit frame and shifts it out.
`default_nettype none
module serial_char_tx #(
  parameter int CNT_W = 19
) (
  input wire logic ref_clk,                // System clock.
  input wire logic rst,                    // Synchronous reset, high.
  input wire logic load,                   // Start a frame with charData.
  input wire logic [7:0] charData,         // Character to send.
  input wire serial_port_pkg::fmt_t fmt,   // Parity and data width.
  input wire logic [CNT_W-1:0] bitCycles,  // Clock cycles per bit.
  output logic txd,                        // Serial line out.
  output logic busy                        // Frame in progress.
);

  logic [serial_port_pkg::FRAME_BITS-1:0] shift_reg;
  logic [serial_port_pkg::FRAME_BITS-1:0] frame;
  logic [3:0] bitsLeft_reg;
  logic [CNT_W-1:0] cyc_reg;
  logic parity;

  // Parity over seven data bits; even makes the count of ones even.
  always_comb begin
    parity = ^charData[6:0];
    if (fmt == serial_port_pkg::FMT_ODD_7) begin
      parity = ~parity;
    end
  end

  // Frame layout, sent from bit 0 upward: start, data, parity, two stops.
  always_comb begin
    if (fmt == serial_port_pkg::FMT_NONE_8) begin
      frame = {2'h3, charData, serial_port_pkg::START_LEVEL};
    end else begin
      frame = {2'h3, parity, charData[6:0],
               serial_port_pkg::START_LEVEL};
    end
  end

  // Shifter: least significant bit first, idle at the stop level.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_reg <= '1;
      bitsLeft_reg <= 4'h0;
      cyc_reg <= '0;
      busy <= 1'b0;
    end else if (load && !busy) begin
      shift_reg <= frame;
      bitsLeft_reg <= 4'(serial_port_pkg::FRAME_BITS);
      cyc_reg <= '0;
      busy <= 1'b1;
    end else if (busy) begin
      if (cyc_reg == bitCycles - 1'b1) begin
        cyc_reg <= '0;
        shift_reg <= {serial_port_pkg::IDLE_LEVEL,
                      shift_reg[serial_port_pkg::FRAME_BITS-1:1]};
        bitsLeft_reg <= bitsLeft_reg - 4'h1;
        if (bitsLeft_reg == 4'h1) begin
          busy <= 1'b0;
        end
      end else begin
        cyc_reg <= cyc_reg + 1'b1;
      end
    end
  end

  assign txd = shift_reg[0];

endmodule
`default_nettype wire

/* File: tb/serial_host_model.sv */
// Host serial port model: sends framed characters and captures output.
`default_nettype none
module serial_host_model (
  input wire logic ref_clk,          // System clock.
  input wire logic [15:0] bitCycles, // Clock cycles per bit.
  input wire logic hostReady,        // Host accepts output.
  input wire logic txd,              // Line from the device.
  output logic rxd,                  // Line toward the device.
  output logic dsr,                  // Data-set-ready, high is true.
  output logic [9:0] gotFrame,       // Bits after start, first at 0.
  output int gotCount                // Characters captured.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Readiness is shown straight on data-set-ready.
  assign dsr = hostReady;

  initial begin
    rxd = 1'h1;
    gotFrame = 10'h0;
    gotCount = 0;
  end

  // Sends a start bit, then data, parity and stops, first bit at 0.
  task automatic send(input logic [9:0] bits);
    @(negedge ref_clk);
    rxd = 1'h0;
    repeat (bitCycles) @(negedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      rxd = bits[i];
      repeat (bitCycles) @(negedge ref_clk);
    end
  endtask

  // Samples each output frame in the middle of its bits.
  always begin
    @(negedge txd);
    repeat (bitCycles / 2) @(posedge ref_clk);
    if (txd === 1'h0) begin
      for (int i = 0; i < 10; i++) begin
        repeat (bitCycles) @(posedge ref_clk);
        gotFrame[i] = txd;
      end
      gotCount++;
    end
  end
endmodule
`default_nettype wire

/* File: tb/serial_port_dtr_dsr_flow_monitor.sv */
// Concurrent checks on the serial port's handshake and mode ports.
`default_nettype none
module serial_port_dtr_dsr_flow_monitor (
  input wire logic ref_clk,         // Clock.
  input wire logic rst,             // Reset.
  input wire logic txd,             // Line out.
  input wire logic dtr,             // Terminal-ready.
  input wire logic dsr,             // Data-set-ready.
  input wire logic rxValid,         // Buffer not empty.
  input wire logic txValid,         // Offer.
  input wire logic txReady,         // Take.
  input wire logic txPaused,        // Paused.
  input wire logic devClear,        // Clear.
  input wire logic cmdRemote,       // Remote.
  input wire logic cmdLocal,        // Local.
  input wire logic cmdLockout,      // Lockout.
  input wire logic cmdEnable,       // Commands run.
  input wire logic localKeyEnable,  // Local key.
  input wire logic panelKeysEnable, // Other keys.
  input wire logic [4:0] busAddr,   // Bus address.
  input wire logic serialSelect,    // Serial active.
  input wire logic talkOnly         // Talk-only.
);
  default clocking mon_clk @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Line and handshake timing.
  chk_idle_line_high: assert property (txReady |-> txd)
    else $error("line not idle while ready");
  chk_take_samples_dsr: assert property ((txValid && txReady) |=>
    (txPaused == !dsr)) else $error("pause does not follow dsr");
  chk_start_bit_low: assert property (txValid && txReady ##1 dsr |=>
    !txd) else $error("no start bit after take");
  chk_resume_on_dsr: assert property (txPaused ##1 dsr |=>
    (!txPaused && !txd)) else $error("no resume on dsr");
  chk_pause_holds_dtr: assert property (txPaused ##1 txPaused |-> !dtr)
    else $error("dtr true while paused");
  chk_clear_frees_dtr: assert property (devClear |-> ##[0:2]
    (dtr && !rxValid)) else $error("clear left hold-off");

  // Front-panel modes and talk-only.
  chk_remote_mode_keys: assert property (cmdRemote && !cmdLockout |=> ##1
    (cmdEnable && localKeyEnable && !panelKeysEnable))
    else $error("remote mode keys wrong");
  chk_lockout_all_keys: assert property (cmdLockout |=> ##1
    (cmdEnable && !localKeyEnable && !panelKeysEnable))
    else $error("lockout keys wrong");
  chk_local_all_keys: assert property (cmdLocal && !cmdRemote &&
    !cmdLockout |=> ##1 (!cmdEnable && localKeyEnable && panelKeysEnable))
    else $error("local keys wrong");
  chk_talk_only_addr: assert property (!$past(rst) |-> talkOnly ==
    ($past(serialSelect) && $past(busAddr) == 5'h1f && panelKeysEnable))
    else $error("talk-only wrong");

  cover property (txPaused ##1 !txPaused);
  cover property (devClear);
  cover property (cmdLockout ##2 !localKeyEnable);
  cover property (talkOnly);
endmodule

bind serial_port_dtr_dsr_flow serial_port_dtr_dsr_flow_monitor
  serial_port_dtr_dsr_flow_monitor_inst (.ref_clk(ref_clk), .rst(rst),
  .txd(txd), .dtr(dtr), .dsr(dsr), .rxValid(rxValid), .txValid(txValid),
  .txReady(txReady), .txPaused(txPaused), .devClear(devClear),
  .cmdRemote(cmdRemote), .cmdLocal(cmdLocal), .cmdLockout(cmdLockout),
  .cmdEnable(cmdEnable), .localKeyEnable(localKeyEnable),
  .panelKeysEnable(panelKeysEnable), .busAddr(busAddr),
  .serialSelect(serialSelect), .talkOnly(talkOnly));
`default_nettype wire

/* File: tb/serial_port_dtr_dsr_flow_bench.sv */
// Self-checking bench for the serial port with hardware hold-off.
`default_nettype none
module serial_port_dtr_dsr_flow_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SIM_HZ = 96000;
  localparam int FULL = 4;
  localparam int OVER = 2;
  typedef struct {
    logic [2:0] sel;
    serial_port_pkg::fmt_t f;
    logic [7:0] c;
    logic [9:0] frame;
    logic [7:0] rx;
  } row_t;
  row_t rows [6] = '{
    '{3'h0, serial_port_pkg::FMT_NONE_8, 8'ha5, 10'h3a5, 8'ha5},
    '{3'h1, serial_port_pkg::FMT_EVEN_7, 8'hb1, 10'h3b1, 8'h31},
    '{3'h2, serial_port_pkg::FMT_ODD_7, 8'h31, 10'h331, 8'h31},
    '{3'h3, serial_port_pkg::FMT_ODD_7, 8'h40, 10'h340, 8'h40},
    '{3'h4, serial_port_pkg::FMT_EVEN_7, 8'hff, 10'h3ff, 8'h7f},
    '{3'h5, serial_port_pkg::FMT_NONE_8, 8'h81, 10'h381, 8'h81}};
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [2:0] baudSel = 3'h5;
  serial_port_pkg::fmt_t fmt = serial_port_pkg::FMT_NONE_8;
  logic [15:0] bitCycles = 16'ha;
  logic rxRead = 1'h0, queryDone = 1'h0, txValid = 1'h0, txLast = 1'h0;
  logic cmdRemote = 1'h0, cmdLocal = 1'h0, cmdLockout = 1'h0;
  logic serialSelect = 1'h0, hostReady = 1'h1;
  logic [4:0] busAddr = 5'h0;
  logic [7:0] txData = 8'h0;
  logic rxd, txd, dtr, dsr, rxValid, msgEnd, rxError, rxOverrun, txReady;
  logic txPaused, devClear, cmdEnable, localKeyEnable, panelKeysEnable;
  logic talkOnly;
  logic [7:0] rxData;
  logic [9:0] gotFrame;
  int gotCount, failures = 0, checkCount = 0, cycles = 0;
  int endCount = 0, clrCount = 0, ovrCount = 0, errCount = 0;

  serial_port_dtr_dsr_flow #(.CLK_HZ(SIM_HZ), .FULL_LEVEL(FULL),
    .OVERRUN(OVER)) serial_port_dtr_dsr_flow_inst (.ref_clk(ref_clk),
    .rst(rst), .baudSel(baudSel), .fmt(fmt), .rxd(rxd), .txd(txd),
    .dtr(dtr), .dsr(dsr), .rxData(rxData), .rxValid(rxValid),
    .rxRead(rxRead), .msgEnd(msgEnd), .rxError(rxError),
    .rxOverrun(rxOverrun), .queryDone(queryDone), .txData(txData),
    .txValid(txValid), .txLast(txLast), .txReady(txReady),
    .txPaused(txPaused), .devClear(devClear), .cmdRemote(cmdRemote),
    .cmdLocal(cmdLocal), .cmdLockout(cmdLockout), .cmdEnable(cmdEnable),
    .localKeyEnable(localKeyEnable), .panelKeysEnable(panelKeysEnable),
    .busAddr(busAddr), .serialSelect(serialSelect), .talkOnly(talkOnly));
  serial_host_model serial_host_model_inst (.ref_clk(ref_clk),
    .bitCycles(bitCycles), .hostReady(hostReady), .txd(txd), .rxd(rxd),
    .dsr(dsr), .gotFrame(gotFrame), .gotCount(gotCount));

  // Makes the 125 MHz clock.
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // Counts the design's pulses and cuts a hang short.
  always @(posedge ref_clk) begin
    cycles++;
    if (msgEnd === 1'h1) endCount++;
    if (devClear === 1'h1) clrCount++;
    if (rxOverrun === 1'h1) ovrCount++;
    if (rxError === 1'h1) errCount++;
    if (cycles > 40000) begin
      failures++;
      stopTest();
    end
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    checkCount++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stopTest();
    if (failures == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Offers one character and holds it until the design takes it.
  task automatic offer(input logic [7:0] c, input logic last);
    int n;
    @(negedge ref_clk);
    txData = c;
    txLast = last;
    txValid = 1'h1;
    #1;
    n = 0;
    while (txReady !== 1'h1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    txValid = 1'h0;
    txLast = 1'h0;
  endtask

  task automatic waitFor(input int target);
    int n;
    n = 0;
    while (gotCount < target && n < 8000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'h1;
    @(negedge ref_clk);
    s = 1'h0;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic host(input logic [9:0] bits);
    serial_host_model_inst.send(bits);
    repeat (4) @(negedge ref_clk);
  endtask

  // Main sequence: reset, the table of frames, then the awkward cases.
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
    check({txd, dtr, rxValid, cmdEnable, localKeyEnable, panelKeysEnable,
      talkOnly, txPaused}, 10'hcc);
    foreach (rows[i]) begin
      baudSel = rows[i].sel;
      fmt = rows[i].f;
      bitCycles = 16'(SIM_HZ / serial_port_pkg::BAUD_RATE[rows[i].sel]);
      offer(rows[i].c, 1'h0);
      waitFor(gotCount + 1);
      check(gotFrame, rows[i].frame);
      host(rows[i].frame);
      check({1'h0, rxValid, rxData}, {2'h1, rows[i].rx});
      pulse(rxRead);
    end
    pulse(cmdRemote);
    check({cmdEnable, localKeyEnable, panelKeysEnable}, 10'h6);
    pulse(cmdLockout);
    check({cmdEnable, localKeyEnable, panelKeysEnable}, 10'h4);
    serialSelect = 1'h1;
    busAddr = 5'h1f;
    pulse(cmdLocal);
    check({talkOnly, cmdEnable, localKeyEnable, panelKeysEnable},
      10'hb);
    busAddr = 5'h1e;
    repeat (2) @(negedge ref_clk);
    check(10'(talkOnly), 10'h0);
    // Fill the input buffer, then send one character more than the host's allowance.
    for (int i = 0; i < FULL; i++) host({2'h3, 8'(8'h41 + i)});
    check(10'(dtr), 10'h0);
    for (int i = 0; i < OVER + 1; i++) host({2'h3, 8'(8'h61 + i)});
    check(10'(ovrCount), 10'h1);
    for (int i = 0; i < 3; i++) pulse(rxRead);
    check({1'h0, dtr, rxData}, {2'h1, 8'h44});
    for (int i = 0; i < 3; i++) pulse(rxRead);
    check(10'(rxValid), 10'h0);
    // Query: CR LF ends it, hold-off lasts until the response is out.
    host({2'h3, serial_port_pkg::CHAR_RETURN});
    host({2'h3, serial_port_pkg::CHAR_NEWLINE});
    check(10'(endCount), 10'h1);
    pulse(rxRead);
    pulse(rxRead);
    pulse(queryDone);
    check(10'(dtr), 10'h0);
    offer(8'h31, 1'h0);
    offer(8'h0a, 1'h1);
    check(10'(dtr), 10'h0);
    waitFor(gotCount + 1);
    repeat (20) @(negedge ref_clk);
    check({1'h0, dtr, gotFrame[7:0]}, 10'h10a);
    // Pause on data-set-ready, resume, then abort a pause with Ctrl-C.
    hostReady = 1'h0;
    offer(8'h55, 1'h0);
    repeat (50) @(negedge ref_clk);
    check({txPaused, dtr, txd, gotFrame[6:0]}, {3'h5, 7'h0a});
    hostReady = 1'h1;
    waitFor(gotCount + 1);
    check(gotFrame, 10'h355);
    hostReady = 1'h0;
    offer(8'h66, 1'h0);
    host({2'h3, 8'h5a});
    host({2'h3, serial_port_pkg::CHAR_CTRL_C});
    check({clrCount[0], txPaused, dtr, rxValid, panelKeysEnable},
      10'h15);
    hostReady = 1'h1;
    repeat (150) @(negedge ref_clk);
    check(gotFrame, 10'h355);
    // Refused frames: a low stop bit, then a wrong even parity.
    host(10'h241);
    fmt = serial_port_pkg::FMT_EVEN_7;
    host(10'h331);
    check({errCount[1:0], rxValid}, 10'h4);
    stopTest();
  end
endmodule
`default_nettype wire
